// ===== obl_pkg.sv
package obl_pkg;
  localparam int unsigned OBL_ADDR_W = 12;
  localparam int unsigned OBL_NUM_BYTES = 5;
  localparam logic [2:0] OBL_NUM_BYTES_3 = 3'h5;
  localparam logic [15:0] OBL_FLASH_BASE_NORMAL = 16'h0080;
  localparam logic [15:0] OBL_FLASH_BASE_SWAP = 16'h1080;
  // register indices; byte address is four times the index
  localparam logic [7:0] OBL_IDX_CLOCK_OPTION_BYTE = 8'h80;
  localparam logic [7:0] OBL_IDX_RESERVED_OPTION_BYTE_A = 8'h81;
  localparam logic [7:0] OBL_IDX_RESERVED_OPTION_BYTE_B = 8'h82;
  localparam logic [7:0] OBL_IDX_RESERVED_OPTION_BYTE_C = 8'h83;
  localparam logic [7:0] OBL_IDX_DEBUG_OPTION_BYTE = 8'h84;
  localparam logic [7:0] OBL_IDX_OSC_MODE = 8'h90;
  localparam logic [7:0] OBL_IDX_LV_MODE = 8'h91;
  localparam logic [7:0] OBL_IDX_LV_LEVEL = 8'h92;
  localparam logic [7:0] OBL_IDX_IRQ_FLAG = 8'h93;
  localparam logic [7:0] OBL_IDX_STATUS = 8'h94;
  localparam int unsigned OBL_BIT_OSC_LOCK = 0;
  localparam int unsigned OBL_BIT_HS_SEL = 1;
  localparam int unsigned OBL_BIT_OSC_STOP = 0;
  localparam int unsigned OBL_BIT_LV_EN = 7;
  localparam int unsigned OBL_BIT_LV_MODE = 1;
  localparam int unsigned OBL_BIT_LV_FLAG = 0;
  localparam int unsigned OBL_BIT_LV_IRQ = 0;
  localparam int unsigned OBL_BIT_ST_DONE = 0;
  localparam int unsigned OBL_BIT_ST_SWAP = 1;
  localparam int unsigned OBL_BIT_ST_CLK_ERR = 2;
  localparam int unsigned OBL_BIT_ST_RSVD_ERR = 3;
  localparam int unsigned OBL_BIT_ST_DBG_ERR = 4;
  localparam logic [7:0] OBL_CLOCK_RSVD_MASK = 8'hfc;
  localparam logic [7:0] OBL_LV_LEVEL_MASK = 8'h0f;
  localparam logic [7:0] OBL_OPT_RST = 8'h00;
  localparam logic [7:0] OBL_OSC_MODE_RST = 8'h00;
  localparam logic [7:0] OBL_LV_MODE_RST = 8'h00;
  localparam logic [7:0] OBL_LV_LEVEL_RST = 8'h00;
  localparam logic [1:0] OBL_RESP_OKAY = 2'h0;
  localparam logic [1:0] OBL_RESP_DECERR = 2'h3;

  function automatic logic [OBL_ADDR_W-1:0] obl_byte_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
endpackage

// ===== obl_fetch_if.sv
interface obl_fetch_if import obl_pkg::*; ();
  logic swap;
  logic done;
  logic [7:0] opt [OBL_NUM_BYTES];
  logic flash_req;
  logic [15:0] flash_addr;
  logic [7:0] flash_rdata;
  logic flash_rvalid;
  modport fetcher(
    input swap, flash_rdata, flash_rvalid,
    output done, opt, flash_req, flash_addr
  );
  modport owner(
    output swap, flash_rdata, flash_rvalid,
    input done, opt, flash_req, flash_addr
  );
endinterface

// ===== obl_fetch.sv
module obl_fetch import obl_pkg::*; (
  input wire logic i_clk,   // system clock
  input wire logic i_rst_n, // sync reset, active low
  obl_fetch_if.fetcher fif  // flash port and fetched bytes
);
  typedef enum logic [1:0] {
    OBL_F_READ = 2'b01,
    OBL_F_DONE = 2'b10
  } obl_fstate_t;

  obl_fstate_t state_reg;
  logic [2:0] cnt_reg;
  logic [15:0] addr_reg;
  logic swap_reg;
  logic [7:0] opt_reg [OBL_NUM_BYTES];
  logic take;

  assign take = (state_reg == OBL_F_READ) && fif.flash_rvalid;
  assign fif.flash_req = (state_reg == OBL_F_READ);
  assign fif.flash_addr = addr_reg;
  assign fif.done = (state_reg == OBL_F_DONE);
  assign fif.opt = opt_reg;

  // every reset restarts the fetch; the swap level is caught while in reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= OBL_F_READ; // see RULE1 RULE11
      cnt_reg <= 3'h0;
      swap_reg <= fif.swap;
      addr_reg <= fif.swap ? OBL_FLASH_BASE_SWAP : OBL_FLASH_BASE_NORMAL; // see RULE2
    end else begin
      unique case (state_reg)
        OBL_F_READ: begin
          if (take) begin
            cnt_reg <= cnt_reg + 3'h1;
            addr_reg <= addr_reg + 16'h0001;
            if (cnt_reg == OBL_NUM_BYTES_3 - 3'h1) begin
              state_reg <= OBL_F_DONE;
            end
          end
        end
        OBL_F_DONE: begin
          state_reg <= OBL_F_DONE;
        end
        default: begin
          state_reg <= OBL_F_READ;
        end
      endcase
    end
  end

  // bytes stay frozen until the next reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < OBL_NUM_BYTES; i++) begin
        opt_reg[i] <= OBL_OPT_RST;
      end
    end else if (take) begin
      opt_reg[cnt_reg] <= fif.flash_rdata; // see RULE16
    end
  end

  fetch_start_a: assert property (@(posedge i_clk) $rose(i_rst_n) |-> fif.flash_req) // see RULE11
    else $error("fetch did not start at reset release");
  fetch_range_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE2
    fif.flash_req |-> fif.flash_addr == (swap_reg ? OBL_FLASH_BASE_SWAP : OBL_FLASH_BASE_NORMAL)
      + {13'h0, cnt_reg})
    else $error("flash address outside option area");
  fetch_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE1
    $rose(fif.done) |-> cnt_reg == OBL_NUM_BYTES_3 && $past(take))
    else $error("fetch ended without five bytes");
endmodule

// ===== obl_top.sv
// Function
// RULE1: read five option bytes after every reset
// RULE2: boot swap fetches from the mirror area
// RULE3: bit 1 selects resonator or RC
// RULE4: lock 0: stop bit halts oscillator
// RULE5: lock 1: oscillator never stops
// RULE6: lock 0: no watchdog clock in HALT/STOP
// RULE7: timer H1 clocked during HALT/STOP
// RULE8: programmer keeps clock byte bits 7:2 zero
// RULE9: programmer writes reserved bytes zero
// RULE10: debug bits must be 00, disabled
// RULE11: load completes before program execution
// RULE12: low-voltage reset may repeat near threshold
// RULE13: software waits fluctuation before port init
// RULE14: handler checks flag, clears request
// RULE15: flag set only while supply below level
// RULE16: loaded values held until next reset
//
// The AXI4-Lite register port was left to the implementer.
module obl_top import obl_pkg::*; (
  input wire logic i_clk,                   // 25 MHz system clock
  input wire logic i_rst_n,                 // sync reset, active low
  input wire logic i_lv_reset_cause,        // reset came from low-voltage detector
  input wire logic i_boot_swap,             // boot swap in effect
  output logic o_flash_req,                 // flash read request
  output logic [15:0] o_flash_addr,         // flash byte address
  input wire logic [7:0] i_flash_rdata,     // flash read data
  input wire logic i_flash_rvalid,          // flash read data valid
  input wire logic i_halt,                  // cpu in HALT
  input wire logic i_stop,                  // cpu in STOP
  input wire logic i_tmh1_internal,         // timer H1 uses internal oscillator
  input wire logic i_lv_below,              // async comparator: supply below level
  output logic o_cpu_release,               // option load finished
  output logic o_hs_clock_source_select,    // 0 resonator, 1 RC
  output logic o_internal_osc_run,          // internal oscillator enable
  output logic o_wdt_clk_en,                // watchdog count clock enable
  output logic o_tmh1_clk_en,               // timer H1 count clock enable
  output logic o_lv_reset_req,              // low-voltage reset request
  output logic o_low_voltage_irq_request,   // low-voltage interrupt request flag
  input wire logic [OBL_ADDR_W-1:0] i_s_axi_awaddr, // write address
  input wire logic i_s_axi_awvalid,         // write address valid
  output logic o_s_axi_awready,             // write address ready
  input wire logic [31:0] i_s_axi_wdata,    // write data
  input wire logic [3:0] i_s_axi_wstrb,     // write strobes
  input wire logic i_s_axi_wvalid,          // write data valid
  output logic o_s_axi_wready,              // write data ready
  output logic [1:0] o_s_axi_bresp,         // write response
  output logic o_s_axi_bvalid,              // write response valid
  input wire logic i_s_axi_bready,          // write response ready
  input wire logic [OBL_ADDR_W-1:0] i_s_axi_araddr, // read address
  input wire logic i_s_axi_arvalid,         // read address valid
  output logic o_s_axi_arready,             // read address ready
  output logic [31:0] o_s_axi_rdata,        // read data
  output logic [1:0] o_s_axi_rresp,         // read response
  output logic o_s_axi_rvalid,              // read data valid
  input wire logic i_s_axi_rready           // read data ready
);
  obl_fetch_if fif ();

  logic done;
  logic lock;
  logic stop_bit;
  logic osc_run;
  logic lv_flag;
  logic lv_meta_reg;
  logic lv_sync_reg;
  logic [7:0] osc_mode_reg;
  logic [7:0] lv_mode_reg;
  logic [7:0] lv_level_reg;
  logic lv_irq_reg;
  logic [7:0] status;
  logic hs_reg;
  logic osc_reg;
  logic wdt_reg;
  logic tmh1_reg;
  logic lvrst_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [OBL_ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic wr_fire;
  logic wr_lane;

  assign fif.swap = i_boot_swap;
  assign fif.flash_rdata = i_flash_rdata;
  assign fif.flash_rvalid = i_flash_rvalid;
  assign o_flash_req = fif.flash_req;
  assign o_flash_addr = fif.flash_addr;

  obl_fetch u_fetch (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .fif(fif.fetcher)
  );

  assign done = fif.done;
  assign o_cpu_release = done; // see RULE11
  assign lock = fif.opt[0][OBL_BIT_OSC_LOCK];
  assign stop_bit = osc_mode_reg[OBL_BIT_OSC_STOP];

  // before the load the oscillator must run, the cpu needs it for reset processing
  assign osc_run = !done || lock || !stop_bit; // see RULE4 RULE5

  // the comparator is analog and asynchronous
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lv_meta_reg <= 1'b0;
      lv_sync_reg <= 1'b0;
    end else begin
      lv_meta_reg <= i_lv_below;
      lv_sync_reg <= lv_meta_reg;
    end
  end

  assign lv_flag = lv_mode_reg[OBL_BIT_LV_EN] && lv_sync_reg; // see RULE15

  assign status = {
    3'h0,
    (fif.opt[4] != OBL_OPT_RST), // see RULE10
    (fif.opt[1] != OBL_OPT_RST) || (fif.opt[2] != OBL_OPT_RST) || (fif.opt[3] != OBL_OPT_RST),
    ((fif.opt[0] & OBL_CLOCK_RSVD_MASK) != OBL_OPT_RST),
    i_boot_swap,
    done
  };

  // clock controls registered so downstream gating sees clean levels
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hs_reg <= 1'b0;
      osc_reg <= 1'b1;
      wdt_reg <= 1'b1;
      tmh1_reg <= 1'b0;
    end else begin
      hs_reg <= done && fif.opt[0][OBL_BIT_HS_SEL]; // see RULE3
      osc_reg <= osc_run;
      wdt_reg <= osc_run && !(done && !lock && (i_halt || i_stop)); // see RULE6
      tmh1_reg <= osc_run && i_tmh1_internal; // see RULE7
    end
  end

  assign o_hs_clock_source_select = hs_reg;
  assign o_internal_osc_run = osc_reg;
  assign o_wdt_clk_en = wdt_reg;
  assign o_tmh1_clk_en = tmh1_reg;

  // a reset it caused itself would repeat while supply hovers near the level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lvrst_reg <= 1'b0;
    end else begin
      lvrst_reg <= lv_flag && lv_mode_reg[OBL_BIT_LV_MODE]; // see RULE12
    end
  end

  assign o_lv_reset_req = lvrst_reg;

  function automatic logic obl_mapped(input logic [OBL_ADDR_W-1:0] a);
    unique case (a)
      obl_byte_addr(OBL_IDX_CLOCK_OPTION_BYTE),
      obl_byte_addr(OBL_IDX_RESERVED_OPTION_BYTE_A),
      obl_byte_addr(OBL_IDX_RESERVED_OPTION_BYTE_B),
      obl_byte_addr(OBL_IDX_RESERVED_OPTION_BYTE_C),
      obl_byte_addr(OBL_IDX_DEBUG_OPTION_BYTE),
      obl_byte_addr(OBL_IDX_OSC_MODE),
      obl_byte_addr(OBL_IDX_LV_MODE),
      obl_byte_addr(OBL_IDX_LV_LEVEL),
      obl_byte_addr(OBL_IDX_IRQ_FLAG),
      obl_byte_addr(OBL_IDX_STATUS): return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic obl_hit(input logic [OBL_ADDR_W-1:0] a, input logic [7:0] idx);
    return a == obl_byte_addr(idx);
  endfunction

  // write channel: address and data may arrive in either order
  assign o_s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign o_s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_lane = wr_fire && wstrb0_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= OBL_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= i_s_axi_wdata[7:0];
        wstrb0_reg <= i_s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= obl_mapped(awaddr_reg) ? OBL_RESP_OKAY : OBL_RESP_DECERR;
      end else if (bvalid_reg && i_s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_mode_reg <= OBL_OSC_MODE_RST;
      lv_level_reg <= OBL_LV_LEVEL_RST;
    end else if (wr_lane && obl_hit(awaddr_reg, OBL_IDX_OSC_MODE)) begin
      osc_mode_reg <= wdata_reg & 8'h01;
    end else if (wr_lane && obl_hit(awaddr_reg, OBL_IDX_LV_LEVEL)) begin
      lv_level_reg <= wdata_reg & OBL_LV_LEVEL_MASK;
    end
  end

  // enable and mode survive a reset raised by the detector itself
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      if (!i_lv_reset_cause) begin
        lv_mode_reg <= OBL_LV_MODE_RST;
      end
    end else if (wr_lane && obl_hit(awaddr_reg, OBL_IDX_LV_MODE)) begin
      lv_mode_reg <= wdata_reg & 8'h82;
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lv_irq_reg <= 1'b0;
    end else if (lv_flag && !lv_mode_reg[OBL_BIT_LV_MODE]) begin
      lv_irq_reg <= 1'b1; // see RULE14
    end else if (wr_lane && obl_hit(awaddr_reg, OBL_IDX_IRQ_FLAG)) begin
      lv_irq_reg <= wdata_reg[OBL_BIT_LV_IRQ];
    end
  end

  assign o_low_voltage_irq_request = lv_irq_reg;

  function automatic logic [7:0] obl_rd(input logic [OBL_ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (obl_hit(a, OBL_IDX_CLOCK_OPTION_BYTE)) v = fif.opt[0];
    if (obl_hit(a, OBL_IDX_RESERVED_OPTION_BYTE_A)) v = fif.opt[1];
    if (obl_hit(a, OBL_IDX_RESERVED_OPTION_BYTE_B)) v = fif.opt[2];
    if (obl_hit(a, OBL_IDX_RESERVED_OPTION_BYTE_C)) v = fif.opt[3];
    if (obl_hit(a, OBL_IDX_DEBUG_OPTION_BYTE)) v = fif.opt[4];
    if (obl_hit(a, OBL_IDX_OSC_MODE)) v = osc_mode_reg;
    if (obl_hit(a, OBL_IDX_LV_MODE)) v = lv_mode_reg | {7'h00, lv_flag};
    if (obl_hit(a, OBL_IDX_LV_LEVEL)) v = lv_level_reg;
    if (obl_hit(a, OBL_IDX_IRQ_FLAG)) v = {7'h00, lv_irq_reg};
    if (obl_hit(a, OBL_IDX_STATUS)) v = status;
    return v;
  endfunction

  assign o_s_axi_arready = !rvalid_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= OBL_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= obl_mapped(i_s_axi_araddr) ? OBL_RESP_OKAY : OBL_RESP_DECERR;
      rdata_reg <= {24'h000000, obl_rd(i_s_axi_araddr)};
    end else if (rvalid_reg && i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rresp = rresp_reg;
  assign o_s_axi_rdata = rdata_reg;

  hs_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE3
    done |=> o_hs_clock_source_select == $past(fif.opt[0][OBL_BIT_HS_SEL]))
    else $error("clock source select does not follow option byte");
  osc_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE4
    done && !lock && stop_bit |=> !o_internal_osc_run)
    else $error("oscillator still running after stop");
  osc_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE5
    done && lock ##1 done |-> o_internal_osc_run)
    else $error("locked oscillator stopped");
  wdt_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE6
    done && !lock && (i_halt || i_stop) |=> !o_wdt_clk_en)
    else $error("watchdog clocked in standby");
  tmh1_run_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE7
    i_tmh1_internal && osc_run && (i_halt || i_stop) |=> o_tmh1_clk_en)
    else $error("timer H1 clock lost in standby");
  opt_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE16
    done ##1 done |-> $stable(fif.opt[0]) && $stable(fif.opt[4]))
    else $error("option values changed after load");
  lv_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE15
    !lv_mode_reg[OBL_BIT_LV_EN] |-> !lv_flag ##1 (lv_irq_reg == $past(lv_irq_reg)) || $past(wr_lane))
    else $error("low-voltage flag set while detection off");
  dbg_check_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RULE10
    done && fif.opt[4][1:0] != 2'h0 |-> status[OBL_BIT_ST_DBG_ERR])
    else $error("prohibited debug setting not reported");
endmodule

// ===== obl_flash_model.sv
module obl_flash_model (
  input wire logic i_clk,               // system clock
  input wire logic i_rst_n,             // sync reset, active low
  input wire logic i_req,               // read request from loader
  input wire logic [15:0] i_addr,       // byte address from loader
  input wire logic [3:0] i_wait,        // wait cycles before each byte
  input wire logic [39:0] i_norm_bytes, // normal area, byte k at bits 8k+7:8k
  input wire logic [39:0] i_mirr_bytes, // boot swap area, same packing
  output logic [7:0] o_rdata,           // read data
  output logic o_rvalid                 // one cycle per byte
);
  logic [3:0] cnt_reg;

  // addresses outside both areas get garbage so a wrong fetch address shows up
  function automatic logic [7:0] pick(input logic [15:0] a);
    logic [2:0] k;
    k = a[2:0];
    if (a[15:3] == 13'h0010 && k < 3'h5) return i_norm_bytes[k*8 +: 8];
    if (a[15:3] == 13'h0210 && k < 3'h5) return i_mirr_bytes[k*8 +: 8];
    return ~o_rdata;
  endfunction

  // at least one idle cycle between bytes: the loader moves its address on the take edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata <= 8'h00;
      cnt_reg <= 4'h0;
    end else if (o_rvalid) begin
      o_rvalid <= 1'b0;
      o_rdata <= ~o_rdata;
      cnt_reg <= 4'h0;
    end else if (i_req && cnt_reg >= i_wait) begin
      o_rvalid <= 1'b1;
      o_rdata <= pick(i_addr);
    end else if (i_req) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule

// ===== tb_option_byte_loader.sv
module tb_option_byte_loader import obl_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, lv_cause = 1'b0, swap = 1'b0, halt = 1'b0, stop = 1'b0;
  logic tmh1 = 1'b0, below = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf, waitn = 4'h0;
  logic [39:0] norm = 40'h0, mirr = 40'h0;
  logic freq, frvalid, release_o, hs, oscrun, wdt, tmh1en, lvrst, irq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] faddr;
  logic [7:0] frdata;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fails, checked;

  initial forever #20 clk = ~clk;

  obl_top u_obl_top (.i_clk(clk), .i_rst_n(rst_n), .i_lv_reset_cause(lv_cause), .i_boot_swap(swap),
    .o_flash_req(freq), .o_flash_addr(faddr), .i_flash_rdata(frdata), .i_flash_rvalid(frvalid),
    .i_halt(halt), .i_stop(stop), .i_tmh1_internal(tmh1), .i_lv_below(below), .o_cpu_release(release_o),
    .o_hs_clock_source_select(hs), .o_internal_osc_run(oscrun), .o_wdt_clk_en(wdt), .o_tmh1_clk_en(tmh1en),
    .o_lv_reset_req(lvrst), .o_low_voltage_irq_request(irq), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

  obl_flash_model u_obl_flash_model (.i_clk(clk), .i_rst_n(rst_n), .i_req(freq), .i_addr(faddr),
    .i_wait(waitn), .i_norm_bytes(norm), .i_mirr_bytes(mirr), .o_rdata(frdata), .o_rvalid(frvalid));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic timeout;
    fails++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    test_done();
  endtask

  // ready is combinational from registers, so its negedge value holds at the next rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      if (tb) check({30'h0, bresp}, {30'h0, er});
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
    end
    if (!tb) timeout();
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rready && rvalid;
      if (tr) begin
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
      end
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
    end
    if (!tr) timeout();
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_reset(input logic sw, input logic lc, input logic [3:0] w);
    int n;
    n = 0;
    @(posedge clk);
    rst_n <= 1'b0;
    swap <= sw;
    lv_cause <= lc;
    waitn <= w;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(release_o, 1'b0);
    while (release_o !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (release_o !== 1'b1) timeout();
    repeat (2) @(negedge clk);
  endtask

  initial begin
    int k;
    fails = 0;
    checked = 0;
    norm = 40'h00_0000_0002;
    // mirror deliberately breaks the programming limits to exercise the status flags
    mirr = 40'h01_0001_0005;
    do_reset(1'b0, 1'b0, 4'h0);
    for (k = 0; k < 5; k++) axi_rd(12'h200 + 12'(4 * k), {24'h0, norm[k*8 +: 8]}, OBL_RESP_OKAY);
    check(hs, 1'b1);
    axi_rd(12'h250, 32'h01, OBL_RESP_OKAY);
    axi_wr(12'h200, 8'hff, OBL_RESP_OKAY);
    axi_rd(12'h200, 32'h02, OBL_RESP_OKAY);
    axi_wr(12'h300, 8'h01, OBL_RESP_DECERR);
    axi_rd(12'h300, 32'h0, OBL_RESP_DECERR);
    // level register keeps only its low nibble; a write without lane 0 is dropped
    axi_wr(12'h248, 8'hff, OBL_RESP_OKAY);
    axi_rd(12'h248, 32'h0f, OBL_RESP_OKAY);
    @(posedge clk);
    wstrb <= 4'he;
    axi_wr(12'h248, 8'h05, OBL_RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(12'h248, 32'h0f, OBL_RESP_OKAY);
    @(posedge clk);
    tmh1 <= 1'b1;
    halt <= 1'b1;
    settle();
    check(wdt, 1'b0);
    check(tmh1en, 1'b1);
    @(posedge clk);
    halt <= 1'b0;
    stop <= 1'b1;
    settle();
    check(wdt, 1'b0);
    check(tmh1en, 1'b1);
    @(posedge clk);
    stop <= 1'b0;
    settle();
    check(wdt, 1'b1);
    axi_wr(12'h240, 8'h01, OBL_RESP_OKAY);
    settle();
    check(oscrun, 1'b0);
    axi_wr(12'h244, 8'h80, OBL_RESP_OKAY);
    @(posedge clk);
    below <= 1'b1;
    settle();
    axi_rd(12'h244, 32'h81, OBL_RESP_OKAY);
    check(irq, 1'b1);
    @(posedge clk);
    below <= 1'b0;
    settle();
    axi_rd(12'h244, 32'h80, OBL_RESP_OKAY);
    axi_wr(12'h24c, 8'h00, OBL_RESP_OKAY);
    settle();
    check(irq, 1'b0);
    axi_wr(12'h244, 8'h82, OBL_RESP_OKAY);
    @(posedge clk);
    below <= 1'b1;
    settle();
    check(lvrst, 1'b1);
    check(irq, 1'b0);
    @(posedge clk);
    below <= 1'b0;
    settle();
    check(lvrst, 1'b0);
    // slow flash and boot swap on the second load
    do_reset(1'b1, 1'b1, 4'h3);
    for (k = 0; k < 5; k++) axi_rd(12'h200 + 12'(4 * k), {24'h0, mirr[k*8 +: 8]}, OBL_RESP_OKAY);
    check(hs, 1'b0);
    axi_rd(12'h250, 32'h1f, OBL_RESP_OKAY);
    axi_rd(12'h244, 32'h82, OBL_RESP_OKAY);
    axi_wr(12'h240, 8'h01, OBL_RESP_OKAY);
    settle();
    check(oscrun, 1'b1);
    @(posedge clk);
    halt <= 1'b1;
    settle();
    check(wdt, 1'b1);
    test_done();
  end
endmodule
